// ### design/motor_ctrl_defs.vh
// register offsets, field positions and reset values for the motor control mode block
// assumes inclusion by the design file, the checker and the bench
`ifndef MOTOR_CTRL_DEFS_VH
`define MOTOR_CTRL_DEFS_VH
`define OFS_PRIMARY     8'h00
`define OFS_SECONDARY   8'h04
`define OFS_PHASE       8'h08
`define OFS_POLARITY    8'h0c
`define OFS_PARITY      8'h10
`define OFS_WEIGHT      8'h14
`define OFS_PREV_Z      8'h18
`define OFS_CUR_Z       8'h1c
`define OFS_COMPARE     8'h20
`define OFS_ZFILTER     8'h24
`define OFS_SAMPLING    8'h28
`define OFS_TIMER       8'h2c
`define OFS_PERIOD      8'h30
`define OFS_DUTY        8'h34
`define OFS_RST_OPTION  8'h38
`define OFS_STATUS      8'h3c
`define B_OUT_EN        7
`define B_CLK_EN        6
`define B_SENSOR        5
`define B_DIRECT        4
`define B_REG_MODE      3
`define B_AUTO_COMM     2
`define B_PZ_GUARD      1
`define B_MULT_SRC      0
`define B_OS0           0
`define B_OS1           1
`define B_OS2           2
`define B_ZSAMP_CTRL    0
`define B_HIGH_RATE     1
`define RST_BYTE        8'h00
`define RST_PERIOD      12'hfff
`define RST_WORD        32'h0000_0000
`define OPT_HIZ         2'h0
`define OPT_LOW         2'h1
`define OPT_HIGH        2'h2
`define IV_AFTER_C      2'h0
`define IV_AFTER_D      2'h1
`define IV_AFTER_Z      2'h2
`define HTRANS_NONSEQ   1
`endif

// ### design/motor_ctrl_mode_register.v
// motor control mode register block with phase output stage, ahb-lite register slave
// assumes one clock hclk, event pins from the analog front end, an inverter on phase pins
`timescale 1ns/1ns
`default_nettype none
`include "motor_ctrl_defs.vh"

// Overview of operation
// - clock enable bit six stops timer, sampling, pwm and all events but a direct access phase write.
// - register writes are accepted even while peripheral clocks are stopped.
// - output enable low forces all six phase outputs to their reset state.
// - each phase reset state is high impedance, high or low per option.
// - clocks off, outputs on, direct access off freezes the outputs not carrying pwm.
// - direct access gives static levels without clocks, pwm with clocks.
// - clocks stopped in voltage mode hold pwm carrying outputs at one.
// - clocks stopped in current mode, direct access off, force pwm carrying outputs to zero.
// - outputs statically high before clocks stop remain high afterwards.
// - twelve bit pwm counter held at zero while clock enable is zero.
// - setting clock enable copies update-preloaded registers to active ones.
// - bit five picks sensor mode; sensor mode skips the d interval.
// - without direct access, phase and mode preloads apply at commutation.
// - direct access phase write makes a commutation; output mode bit zero places pwm.
// - direct access outputs follow phase state with polarity, parity, pwm.
// - bit three picks voltage regulation at zero, current at one.
// - bit two picks auto commutation; next compare stays read-write, but an auto load in the same cycle wins over a write.
// - parasitic zero guard set makes the z event filter ignored.
// - bit zero picks capture source; compare equals weight times capture over 256.
// - outputs off, sensorless, slow sampling: z sampling per control bit, else d.
// - bit seven is output enable; clear resets phase outputs, set enables.
module motor_ctrl_mode_register (
  // clock, reset, freeze
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // event pins
  input  wire        c_event_pin,
  input  wire        d_event_pin,
  input  wire        z_event_pin,
  // phase outputs
  output reg  [5:0]  phase_outputs,
  output reg  [5:0]  phase_outputs_oe_n,
  // sampling state
  output reg         z_sampling_on,
  output reg         d_sampling_on
);
  integer i;
  reg  [7:0]  primary_q, secondary_q, phase_state_q, polarity_q, parity_q, weight_q;
  reg  [7:0]  prev_z_q, cur_z_q, compare_q, zfilter_q, sampling_q, timer_q;
  reg  [11:0] period_q, duty_pre_q, duty_act_q, pwm_cnt_q, rst_option_q;
  reg  [5:0]  phase_act_q, applied_q;
  reg         os2_act_q, cke_prev_q;
  reg  [1:0]  interval_q;
  reg  [3:0]  zcount_q;
  reg  [2:0]  c_sync_q, d_sync_q, z_sync_q;
  reg         wr_pend_q, rd_pend_q;
  reg  [7:0]  addr_q;
  reg  [5:0]  out_d, oe_n_d, app_d;
  reg  [31:0] rdata_d;
  reg         lvl, pwm_here, hi_side, sel;
  wire        phase_output_enable = primary_q[`B_OUT_EN];
  wire        cke = primary_q[`B_CLK_EN];
  wire        dac = primary_q[`B_DIRECT];
  wire        vocl = primary_q[`B_REG_MODE];
  wire        accept = hsel & hready & htrans[`HTRANS_NONSEQ];
  wire        wr_now = wr_pend_q;
  wire        wr_phase = wr_now & (addr_q == `OFS_PHASE);
  wire        pwm_wrap = cke & (pwm_cnt_q >= period_q);
  wire        high_rate = sampling_q[`B_HIGH_RATE];
  wire        c_rise = c_sync_q[1] & ~c_sync_q[2];
  wire        d_rise = d_sync_q[1] & ~d_sync_q[2];
  wire        z_seen = z_sync_q[1];
  wire        auto_comm = primary_q[`B_AUTO_COMM];
  wire        z_samp_run = phase_output_enable | primary_q[`B_SENSOR] | high_rate | sampling_q[`B_ZSAMP_CTRL];
  wire        z_strobe = cke & z_samp_run & (high_rate | pwm_wrap);
  wire        z_pass = primary_q[`B_PZ_GUARD] | (zcount_q >= zfilter_q[3:0]);
  wire        z_event = z_strobe & z_seen & z_pass & (interval_q != `IV_AFTER_Z);
  wire        d_event = cke & d_rise & ~primary_q[`B_SENSOR] & (interval_q == `IV_AFTER_C);
  wire        c_hw = auto_comm ? (timer_q == compare_q) & (interval_q == `IV_AFTER_Z) : c_rise;
  wire        c_event = (cke & c_hw & ~dac) | (wr_phase & dac);
  wire [15:0] product = weight_q * (primary_q[`B_MULT_SRC] ? timer_q : cur_z_q);

  // pwm level of the generator
  function pwm_level;
    input [11:0] cnt;
    input [11:0] duty;
    begin
      pwm_level = cnt < duty;
    end
  endfunction

  // reset-state level of one phase from its option pair
  function opt_level;
    input [1:0] opt;
    begin
      opt_level = (opt == `OPT_HIGH);
    end
  endfunction

  // z counts at once in sensor mode, only after d when sensorless
  function z_allowed;
    input       sensor;
    input [1:0] iv;
    begin
      z_allowed = sensor | (iv == `IV_AFTER_D);
    end
  endfunction

  // ahb-lite slave: writes zero-wait, reads one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= `RST_BYTE;
      hrdata <= `RST_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= accept & hwrite;
      rd_pend_q <= accept & ~hwrite;
      if (accept) begin
        addr_q <= haddr[7:0];
      end
      if (accept & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout <= 1'b1;
        hrdata <= rdata_d;
      end
    end
  end

  // read multiplexer
  always @* begin
    rdata_d = `RST_WORD;
    case (addr_q)
      `OFS_PRIMARY:    rdata_d[7:0] = primary_q;
      `OFS_SECONDARY:  rdata_d[7:0] = secondary_q;
      `OFS_PHASE:      rdata_d[7:0] = phase_state_q;
      `OFS_POLARITY:   rdata_d[7:0] = polarity_q;
      `OFS_PARITY:     rdata_d[7:0] = parity_q;
      `OFS_WEIGHT:     rdata_d[7:0] = weight_q;
      `OFS_PREV_Z:     rdata_d[7:0] = prev_z_q;
      `OFS_CUR_Z:      rdata_d[7:0] = cur_z_q;
      `OFS_COMPARE:    rdata_d[7:0] = compare_q;
      `OFS_ZFILTER:    rdata_d[7:0] = zfilter_q;
      `OFS_SAMPLING:   rdata_d[7:0] = sampling_q;
      `OFS_TIMER:      rdata_d[7:0] = timer_q;
      `OFS_PERIOD:     rdata_d[11:0] = period_q;
      `OFS_DUTY:       rdata_d[11:0] = duty_pre_q;
      `OFS_RST_OPTION: rdata_d[11:0] = rst_option_q;
      `OFS_STATUS:     rdata_d[15:0] = {interval_q, os2_act_q, z_sampling_on, phase_act_q, 2'h0, applied_q[5:2]};
      default:         rdata_d = `RST_WORD;
    endcase
  end

  // software registers, writable whether clocks run or not
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_q <= `RST_BYTE;
      secondary_q <= `RST_BYTE;
      phase_state_q <= `RST_BYTE;
      polarity_q <= `RST_BYTE;
      parity_q <= `RST_BYTE;
      weight_q <= `RST_BYTE;
      zfilter_q <= `RST_BYTE;
      sampling_q <= `RST_BYTE;
      period_q <= `RST_PERIOD;
      duty_pre_q <= 12'h000;
      rst_option_q <= 12'h000;
    end else if (ce && wr_now) begin
      case (addr_q)
        `OFS_PRIMARY:    primary_q <= hwdata[7:0];
        `OFS_SECONDARY:  secondary_q <= hwdata[7:0];
        `OFS_PHASE:      phase_state_q <= hwdata[7:0];
        `OFS_POLARITY:   polarity_q <= hwdata[7:0];
        `OFS_PARITY:     parity_q <= hwdata[7:0];
        `OFS_WEIGHT:     weight_q <= hwdata[7:0];
        `OFS_ZFILTER:    zfilter_q <= hwdata[7:0];
        `OFS_SAMPLING:   sampling_q <= hwdata[7:0];
        `OFS_PERIOD:     period_q <= hwdata[11:0];
        `OFS_DUTY:       duty_pre_q <= hwdata[11:0];
        `OFS_RST_OPTION: rst_option_q <= hwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // event pin synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_sync_q <= 3'h0;
      d_sync_q <= 3'h0;
      z_sync_q <= 3'h0;
    end else if (ce) begin
      c_sync_q <= {c_sync_q[1:0], c_event_pin};
      d_sync_q <= {d_sync_q[1:0], d_event_pin};
      z_sync_q <= {z_sync_q[1:0], z_event_pin};
    end
  end

  // pwm generator with update preload
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_cnt_q <= 12'h000;
      duty_act_q <= 12'h000;
      cke_prev_q <= 1'b0;
    end else if (ce) begin
      cke_prev_q <= cke;
      if (!cke) begin
        pwm_cnt_q <= 12'h000;
      end else if (pwm_wrap) begin
        pwm_cnt_q <= 12'h000;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 12'h001;
      end
      if (cke && (!cke_prev_q || pwm_wrap)) begin
        duty_act_q <= duty_pre_q;
      end
    end
  end

  // commutation sequencer, z filter, timer and multiplier
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interval_q <= `IV_AFTER_C;
      zcount_q <= 4'h0;
      timer_q <= `RST_BYTE;
      prev_z_q <= `RST_BYTE;
      cur_z_q <= `RST_BYTE;
      compare_q <= `RST_BYTE;
      phase_act_q <= 6'h00;
      os2_act_q <= 1'b0;
    end else if (ce) begin
      if (z_strobe) begin
        if (!z_seen) begin
          zcount_q <= 4'h0;
        end else if (!z_pass) begin
          zcount_q <= zcount_q + 4'h1;
        end
      end
      if (c_event) begin
        if (wr_phase & dac) begin
          phase_act_q <= hwdata[5:0];
        end else begin
          phase_act_q <= phase_state_q[5:0];
        end
        os2_act_q <= secondary_q[`B_OS2];
        interval_q <= `IV_AFTER_C;
        zcount_q <= 4'h0;
      end else if (d_event) begin
        interval_q <= `IV_AFTER_D;
      end else if (z_event && z_allowed(primary_q[`B_SENSOR], interval_q)) begin
        interval_q <= `IV_AFTER_Z;
      end
      if (wr_now && addr_q == `OFS_TIMER) begin
        timer_q <= hwdata[7:0];
      end else if (c_event && cke) begin
        timer_q <= `RST_BYTE;
      end else if (cke) begin
        timer_q <= timer_q + 8'h01;
      end
      if (z_event && z_allowed(primary_q[`B_SENSOR], interval_q)) begin
        prev_z_q <= cur_z_q;
        cur_z_q <= timer_q;
      end
      if (z_event && auto_comm && z_allowed(primary_q[`B_SENSOR], interval_q)) begin
        compare_q <= product[15:8];
      end else if (wr_now && addr_q == `OFS_COMPARE) begin
        compare_q <= hwdata[7:0];
      end
    end
  end

  // phase output stage
  always @* begin
    out_d = phase_outputs;
    oe_n_d = phase_outputs_oe_n;
    app_d = applied_q;
    lvl = 1'b0;
    pwm_here = 1'b0;
    hi_side = 1'b0;
    sel = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      hi_side = (i % 2 == 0) ^ parity_q[i];
      if (dac) begin
        sel = secondary_q[`B_OS0];
      end else begin
        case (interval_q)
          `IV_AFTER_C: sel = os2_act_q;
          `IV_AFTER_D: sel = secondary_q[`B_OS1];
          default:     sel = secondary_q[`B_OS0];
        endcase
      end
      pwm_here = phase_act_q[i] & (hi_side ? ~sel : sel);
      if (!phase_output_enable) begin
        out_d[i] = opt_level(rst_option_q[2*i +: 2]);
        oe_n_d[i] = (rst_option_q[2*i +: 2] == `OPT_HIZ);
        app_d[i] = 1'b0;
      end else if (cke) begin
        lvl = pwm_here ? pwm_level(pwm_cnt_q, duty_act_q) : phase_act_q[i];
        out_d[i] = lvl ^ polarity_q[i];
        oe_n_d[i] = 1'b0;
        app_d[i] = pwm_here;
      end else if (dac) begin
        out_d[i] = phase_act_q[i] ^ polarity_q[i];
        oe_n_d[i] = 1'b0;
        app_d[i] = 1'b0;
      end else if (applied_q[i]) begin
        out_d[i] = ~vocl ^ polarity_q[i];
        oe_n_d[i] = 1'b0;
      end else begin
        out_d[i] = phase_outputs[i];
        oe_n_d[i] = 1'b0;
      end
    end
  end

  // output and sampling flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_outputs <= 6'h00;
      phase_outputs_oe_n <= 6'h3f;
      applied_q <= 6'h00;
      z_sampling_on <= 1'b0;
      d_sampling_on <= 1'b0;
    end else if (ce) begin
      phase_outputs <= out_d;
      phase_outputs_oe_n <= oe_n_d;
      applied_q <= app_d;
      z_sampling_on <= cke & z_samp_run;
      d_sampling_on <= cke & ~z_samp_run;
    end
  end
endmodule
`default_nettype wire

// ### testbench/motor_ctrl_mode_register_checker.sv
// port checks for the motor control mode block
// assumes one ahb-lite master and the design header on the include path
`timescale 1ns/1ns
`default_nettype none
`include "motor_ctrl_defs.vh"
module motor_ctrl_mode_register_checker (
  // clock, reset, freeze
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  // ahb-lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  // phase outputs
  input wire logic [5:0]  phase_outputs,
  input wire logic [5:0]  phase_outputs_oe_n
);
  logic        ap_q, aw_q;
  logic [7:0]  aa_q, prim_q;
  logic [5:0]  ph_q, pol_q;
  logic [11:0] opt_q;
  wire         take = hsel && hready && htrans[1] && ce;
  function automatic logic [5:0] rlvl(input logic [11:0] o, input logic [1:0] v);
    for (int i = 0; i < 6; i++) rlvl[i] = (o[2*i+:2] == v);
  endfunction
  // shadow copies of the registers that steer the phase outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ap_q, aw_q, aa_q, prim_q, ph_q, pol_q, opt_q} <= '0;
    end else begin
      if (hready) begin
        ap_q <= take;
        aw_q <= hwrite;
        aa_q <= haddr[7:0];
      end
      if (ap_q && aw_q && hready) begin
        if (aa_q == `OFS_PRIMARY) prim_q <= hwdata[7:0];
        if (aa_q == `OFS_PHASE) ph_q <= hwdata[5:0];
        if (aa_q == `OFS_POLARITY) pol_q <= hwdata[5:0];
        if (aa_q == `OFS_RST_OPTION) opt_q <= hwdata[11:0];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_held;
    (prim_q[7:6] == 2'b10 && $stable({prim_q, ph_q, pol_q})) [*3];
  endsequence
  a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_read_back: assert property (take && !hwrite && haddr[7:0] == `OFS_PRIMARY |=> s_rd_wait ##0 hrdata == {24'h0, prim_q})
    else $error("control byte read back wrong");
  a_reset_level: assert property (!prim_q[7] |=> phase_outputs == rlvl($past(opt_q), `OPT_HIGH))
    else $error("reset level wrong");
  a_reset_drive: assert property (!prim_q[7] |=> phase_outputs_oe_n == rlvl($past(opt_q), `OPT_HIZ))
    else $error("reset drive wrong");
  a_drive_on: assert property (prim_q[7] |=> phase_outputs_oe_n == 6'h00)
    else $error("enabled output not driven");
  a_frozen_hold: assert property (s_held |-> $stable(phase_outputs))
    else $error("output moved with clocks stopped");
  a_stop_volt: assert property ($fell(prim_q[6]) && prim_q[7] && prim_q[4:3] == 2'b00 && pol_q == 6'h00
    |=> ($past(phase_outputs) & ~phase_outputs) == 6'h00) else $error("output fell at voltage mode stop");
  a_stop_curr: assert property ($fell(prim_q[6]) && prim_q[7] && prim_q[4:3] == 2'b01 && pol_q == 6'h00
    |=> (~$past(phase_outputs) & phase_outputs) == 6'h00) else $error("output rose at current mode stop");
endmodule
`default_nettype wire

// ### testbench/inverter_stage_model.sv
// inverter and motor stand-in: a turning rotor reporting its events
// assumes the phase drive enables of the block; slow stretches each step
`timescale 1ns/1ns
`default_nettype none
module inverter_stage_model (
  // clock, reset, pace
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       slow,
  // phase drive
  input  wire logic [5:0] phase_outputs_oe_n,
  // sensed events
  output wire logic       c_event_pin,
  output wire logic       d_event_pin,
  output wire logic       z_event_pin
);
  logic [7:0] cnt_q;
  wire  [7:0] step = slow ? 8'h18 : 8'h06;
  // all legs floating gives no back-emf, so the rotor count returns to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 8'h00;
    else if (&phase_outputs_oe_n || cnt_q >= 8'h03 * step) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign d_event_pin = (cnt_q == step);
  assign z_event_pin = (cnt_q >= 8'h02 * step);
  assign c_event_pin = (cnt_q == 8'h03 * step);
endmodule
`default_nettype wire

// ### testbench/test_motor_ctrl_mode_register.sv
// self-checking bench for the motor control mode block
// assumes the design header on the include path
`timescale 1ns/1ns
`default_nettype none
`include "motor_ctrl_defs.vh"
module test_motor_ctrl_mode_register;
  logic        hclk, hresetn, ce, hsel, hwrite, slow, hready, hreadyout, hresp;
  logic        c_event_pin, d_event_pin, z_event_pin, z_sampling_on, d_sampling_on;
  logic [31:0] haddr, hwdata, hrdata, rd, seed, zp, zc;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  phase_outputs, phase_outputs_oe_n;
  int          n_fail, checks, cyc, hi0, hi1;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  motor_ctrl_mode_register DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .c_event_pin, .d_event_pin, .z_event_pin, .phase_outputs, .phase_outputs_oe_n,
    .z_sampling_on, .d_sampling_on);
  inverter_stage_model motor (.hclk, .hresetn, .slow, .phase_outputs_oe_n, .c_event_pin, .d_event_pin, .z_event_pin);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // {drive enables low-active, levels} of the reset state
  function automatic logic [11:0] rst_exp(input logic [11:0] op);
    for (int i = 0; i < 6; i++) begin
      rst_exp[i] = (op[2*i+:2] == `OPT_HIGH);
      rst_exp[i+6] = (op[2*i+:2] == `OPT_HIZ);
    end
  endfunction
  // next compare: weight times capture over 256
  function automatic logic [7:0] mul_exp(input logic [7:0] w, input logic [7:0] z);
    logic [15:0] p;
    p = w * z;
    return p[15:8];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pwm_count;
    hi0 = 0;
    hi1 = 0;
    repeat (32) begin
      @(posedge hclk);
      hi0 += phase_outputs[0];
      hi1 += phase_outputs[1];
    end
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsize = 3'h2;
    {hsel, hwrite, htrans, haddr, hwdata, slow} = '0;
    {n_fail, checks, cyc} = '0;
    seed = 32'h0000_002d;
    wt(8);
    hresetn <= 1'b1;
    xfer(1'b0, `OFS_PRIMARY, 0);
    chk("control reset", 0, rd);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      slow <= seed[31];
      xfer(1'b1, `OFS_PRIMARY, seed[6:0] & 7'h7b);
      xfer(1'b0, `OFS_PRIMARY, 0);
      chk("control", seed[6:0] & 7'h7b, rd);
      xfer(1'b1, `OFS_COMPARE, seed[15:8]);
      xfer(1'b0, `OFS_COMPARE, 0);
      chk("next compare", seed[15:8], rd);
      xfer(1'b1, `OFS_RST_OPTION, seed[27:16]);
      wt(2);
      chk("reset state", rst_exp(seed[27:16]), {phase_outputs_oe_n, phase_outputs});
    end
    xfer(1'b1, 8'h40, 32'hffff_ffff);
    xfer(1'b0, 8'h40, 0);
    chk("unmapped", 0, rd);
    chk("response", 0, hresp);
    $display("register test done");
    seed = xs(seed);
    xfer(1'b1, `OFS_PRIMARY, 8'h90);
    xfer(1'b1, `OFS_POLARITY, seed[5:0]);
    xfer(1'b1, `OFS_PHASE, seed[13:8]);
    wt(3);
    chk("direct static", seed[5:0] ^ seed[13:8], {phase_outputs_oe_n, phase_outputs});
    $display("direct static test done");
    xfer(1'b1, `OFS_POLARITY, 0);
    xfer(1'b1, `OFS_PERIOD, 12'h00f);
    xfer(1'b1, `OFS_DUTY, 12'h008);
    xfer(1'b1, `OFS_PRIMARY, 8'hd0);
    for (int s = 1; s >= 0; s--) begin
      xfer(1'b1, `OFS_SECONDARY, s);
      xfer(1'b1, `OFS_PHASE, 6'h3f);
      wt(4);
      pwm_count();
      chk("channel 0 high", s ? 32 : 16, hi0);
      chk("channel 1 high", s ? 16 : 32, hi1);
    end
    $display("direct pwm test done");
    for (int m = 0; m < 2; m++) begin
      xfer(1'b1, `OFS_PRIMARY, m ? 8'hc8 : 8'hc0);
      wt(20);
      xfer(1'b1, `OFS_PRIMARY, m ? 8'h88 : 8'h80);
      wt(3);
      chk("stopped level", m ? 6'h2a : 6'h3f, phase_outputs);
    end
    $display("clock stop test done");
    xfer(1'b1, `OFS_RST_OPTION, 0);
    xfer(1'b1, `OFS_PRIMARY, 8'hc0);
    xfer(1'b1, `OFS_PRIMARY, 8'h40);
    xfer(1'b1, `OFS_PRIMARY, 0);
    wt(2);
    chk("reset state", 12'hfc0, {phase_outputs_oe_n, phase_outputs});
    xfer(1'b1, `OFS_PRIMARY, 8'h40);
    for (int z = 0; z < 2; z++) begin
      xfer(1'b1, `OFS_SAMPLING, z);
      wt(3);
      chk("sampling select", {z[0], ~z[0]}, {z_sampling_on, d_sampling_on});
    end
    $display("exit and sampling test done");
    xfer(1'b1, `OFS_SAMPLING, 2);
    xfer(1'b1, `OFS_ZFILTER, 32'h0f);
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      xfer(1'b1, `OFS_WEIGHT, seed[7:0]);
      xfer(1'b1, `OFS_PRIMARY, 8'he6 | k);
      wt(600);
      xfer(1'b1, `OFS_PRIMARY, 8'h26 | k);
      xfer(1'b0, `OFS_PREV_Z, 0);
      zp = rd;
      xfer(1'b0, `OFS_CUR_Z, 0);
      zc = rd;
      xfer(1'b0, `OFS_COMPARE, 0);
      chk("multiplier", mul_exp(seed[7:0], k ? zc[7:0] : zp[7:0]), rd);
    end
    xfer(1'b1, `OFS_TIMER, seed[15:8]);
    wt(5);
    xfer(1'b0, `OFS_TIMER, 0);
    chk("timer held", seed[15:8], rd);
    $display("multiplier and timer test done");
    results();
  end
endmodule
bind motor_ctrl_mode_register motor_ctrl_mode_register_checker chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .phase_outputs, .phase_outputs_oe_n);
`default_nettype wire
